// ==== hdl/dual_clock_sync_fifo.sv ====
// dual clock fifo core with flags, replay and depth cascade
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "fifo_defs.svh"
module dual_clock_sync_fifo #(
  parameter int AW = `FIFO_AW_DEF,
  parameter int DW = `FIFO_DW_DEF
) (
  input  logic          i_clk,
  input  logic          i_rst_n,
  input  logic          i_hsel,
  input  logic [31:0]   i_haddr,
  input  logic [1:0]    i_htrans,
  input  logic          i_hwrite,
  input  logic [2:0]    i_hsize,
  input  logic [31:0]   i_hwdata,
  input  logic          i_hready,
  output logic          o_hreadyout,
  output logic [31:0]   o_hrdata,
  output logic          o_hresp,
  input  logic          i_wclk,
  input  logic          i_rclk,
  input  logic          i_wen_n,
  input  logic          i_ren_n,
  input  logic          i_oe_n,
  input  logic [DW-1:0] i_d,
  input  logic          i_replay_pulse,
  input  logic          i_sync_flag_sel,
  input  logic          i_dev_rst_n,
  input  logic          i_wr_cascade_in_n,
  input  logic          i_rd_cascade_in_n,
  output logic [DW-1:0] o_q,
  output logic          o_q_oe_n,
  output logic          o_empty_n,
  output logic          o_full_n,
  output logic          o_almost_empty_n,
  output logic          o_almost_full_n,
  output logic          o_half_full_n,
  output logic          o_wr_cascade_out_n,
  output logic          o_rd_cascade_out_n
);
  import fifo_pkg::*;

  localparam int DEPTH = 1 << AW;
  localparam int PW    = AW + 1;
  localparam int SW    = DW + 10;
  localparam int CW    = 16;
  localparam int AGE_W = 4;

  typedef struct packed {
    mode_t           mode;
    logic [PW-1:0]   wptr;
    logic [PW-1:0]   rptr;
    logic [PW-1:0]   rptr_w;
    logic [PW-1:0]   rptr_p;
    logic [PW-1:0]   wptr_r;
    logic [PW-1:0]   wptr_p;
    logic [AGE_W-1:0] w_age;
    logic [AGE_W-1:0] r_age;
    logic [AGE_W-1:0] rec_cnt;
    logic            wclk_q;
    logic            rclk_q;
    logic            wci_q;
    logic            rci_q;
    logic            wtok;
    logic            rtok;
    logic [DW-1:0]   q;
    logic            q_oe_n;
    logic            empty_n;
    logic            full_n;
    logic            aempty_n;
    logic            afull_n;
    logic            half_n;
    logic            wco_n;
    logic            rco_n;
  } core_st_t;

  localparam core_st_t ST_RST = '{mode: M_RST, q_oe_n: 1'b1,
    full_n: 1'b1, afull_n: 1'b1, half_n: 1'b1, wco_n: 1'b1,
    rco_n: 1'b1, wci_q: 1'b1, rci_q: 1'b1, default: '0};

  fifo_cfg_if cfg ();

  logic [1:0]    rst_sync_ff;
  logic          rst_n;
  logic [SW-1:0] sync_lvl;
  logic          s_wclk;
  logic          s_rclk;
  logic          s_wen_n;
  logic          s_ren_n;
  logic          s_oe_n;
  logic          s_replay;
  logic          s_sel;
  logic          s_dev_rst_n;
  logic          s_wci_n;
  logic          s_rci_n;
  logic [DW-1:0] s_d;
  core_st_t      st_ff;
  core_st_t      nxt_st;
  logic          wedge;
  logic          redge;
  logic          run;
  logic          wr_ok;
  logic          rd_ok;
  logic [PW-1:0] nwptr;
  logic [PW-1:0] nrptr;
  logic [PW-1:0] cnt_live;
  logic [PW-1:0] cnt_wf;
  logic [PW-1:0] cnt_wp;
  logic [PW-1:0] cnt_re;
  logic [PW-1:0] cnt_rp;
  logic [DW-1:0] mem [DEPTH];

  // count at or above depth minus m
  function automatic logic over_off(input logic [PW-1:0]     c,
                                    input logic [`OFF_W-1:0] m);
    return (CW'(c) + CW'(m)) >= CW'(DEPTH);
  endfunction : over_off

  // count at or below n; a stale view past the reader reads as empty
  function automatic logic under_off(input logic [PW-1:0]     c,
                                     input logic [`OFF_W-1:0] n);
    return (CW'(c) > CW'(DEPTH)) || (CW'(c) <= CW'(n));
  endfunction : under_off

  function automatic logic [AGE_W-1:0] sat(input logic [AGE_W-1:0] a);
    return (a == '1) ? a : a + 1'b1;
  endfunction : sat

  // bus reset is released through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // pins and the two external clocks are sampled, not used as clocks
  pin_sync #(
    .W       (SW),
    .RST_VAL ({10'h0E3, {DW{1'b0}}})
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_pin   ({i_wclk, i_rclk, i_wen_n, i_ren_n, i_oe_n, i_replay_pulse,
               i_sync_flag_sel, i_dev_rst_n, i_wr_cascade_in_n,
               i_rd_cascade_in_n, i_d}),
    .o_lvl   (sync_lvl)
  );
  assign {s_wclk, s_rclk, s_wen_n, s_ren_n, s_oe_n, s_replay, s_sel,
          s_dev_rst_n, s_wci_n, s_rci_n, s_d} = sync_lvl;

  fifo_regs u_regs (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hrdata    (o_hrdata),
    .o_hresp     (o_hresp),
    .cfg         (cfg)
  );

  // edges of the sampled clocks and the accepted transfers
  assign wedge = s_wclk & ~st_ff.wclk_q;
  assign redge = s_rclk & ~st_ff.rclk_q;
  assign run   = (st_ff.mode == M_RUN);
  assign wr_ok = wedge & ~s_wen_n & st_ff.full_n & run
               & (~cfg.casc_en | st_ff.wtok);
  assign rd_ok = redge & ~s_ren_n & st_ff.empty_n & run
               & (~cfg.casc_en | st_ff.rtok);
  assign nwptr    = st_ff.wptr + PW'(wr_ok);
  assign nrptr    = st_ff.rptr + PW'(rd_ok);
  assign cnt_live = st_ff.wptr - st_ff.rptr;
  assign cnt_wf   = nwptr - st_ff.rptr_w;
  assign cnt_wp   = nwptr - st_ff.rptr_p;
  assign cnt_re   = st_ff.wptr_r - nrptr;
  assign cnt_rp   = st_ff.wptr_p - nrptr;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.wclk_q = s_wclk;
    nxt_st.rclk_q = s_rclk;
    nxt_st.wci_q  = s_wci_n;
    nxt_st.rci_q  = s_rci_n;
    nxt_st.wptr   = nwptr;
    nxt_st.rptr   = nrptr;
    nxt_st.wco_n  = 1'b1;
    nxt_st.rco_n  = 1'b1;
    if (rd_ok) nxt_st.q = mem[st_ff.rptr[AW-1:0]];
    // a pointer copy crosses only after it has stood for the skew time
    nxt_st.w_age = wr_ok ? '0 : sat(st_ff.w_age);
    nxt_st.r_age = (rd_ok | ~run) ? '0 : sat(st_ff.r_age);
    if (st_ff.r_age >= AGE_W'(`FULL_SKEW_CYC))
      nxt_st.rptr_w = st_ff.rptr;
    if (st_ff.r_age >= AGE_W'(`PROG_SKEW_CYC))
      nxt_st.rptr_p = st_ff.rptr;
    if (st_ff.w_age >= AGE_W'(`EMPTY_SKEW_CYC))
      nxt_st.wptr_r = st_ff.wptr;
    if (st_ff.w_age >= AGE_W'(`PROG_SKEW_CYC))
      nxt_st.wptr_p = st_ff.wptr;
    // boundary flags move only on their own side's edge
    if (wedge & run) begin
      nxt_st.full_n = (cnt_wf != PW'(DEPTH));
      if (!s_sel) nxt_st.afull_n = !over_off(cnt_wp, cfg.full_off);
    end
    if (redge & run) begin
      nxt_st.empty_n = (cnt_re != '0);
      if (!s_sel) nxt_st.aempty_n = !under_off(cnt_rp, cfg.empty_off);
    end
    // select high: almost flags follow the live count every cycle
    if (s_sel) begin
      nxt_st.afull_n  = !over_off(cnt_live, cfg.full_off);
      nxt_st.aempty_n = !under_off(cnt_live, cfg.empty_off);
    end
    nxt_st.half_n = !(CW'(cnt_live) > CW'(DEPTH / 2));
    // cascade hand-off; an incoming token wins over an outgoing one
    if (wr_ok & cfg.casc_en & (st_ff.wptr[AW-1:0] == '1)) begin
      nxt_st.wco_n = 1'b0;
      nxt_st.wtok  = 1'b0;
    end
    if (rd_ok & cfg.casc_en & (st_ff.rptr[AW-1:0] == '1)) begin
      nxt_st.rco_n = 1'b0;
      nxt_st.rtok  = 1'b0;
    end
    if (st_ff.wci_q & ~s_wci_n) nxt_st.wtok = 1'b1;
    if (st_ff.rci_q & ~s_rci_n) nxt_st.rtok = 1'b1;
    nxt_st.q_oe_n = s_oe_n | (cfg.casc_en & ~st_ff.rtok);
    unique case (st_ff.mode)
      M_RST: nxt_st.mode = M_RUN;
      M_RUN: begin
        // replay only applies stand-alone or in width expansion
        if (s_replay & ~cfg.casc_en) begin
          nxt_st.mode    = M_REPLAY;
          nxt_st.rec_cnt = '0;
        end
      end
      M_REPLAY: begin
        nxt_st.rptr = '0;
        if (s_replay) begin
          nxt_st.rec_cnt = '0;
        end else if (st_ff.rec_cnt == AGE_W'(`REPLAY_CYC)) begin
          // recovery over: every flag recomputed from live pointers
          nxt_st.mode     = M_RUN;
          nxt_st.rptr_w   = st_ff.rptr;
          nxt_st.rptr_p   = st_ff.rptr;
          nxt_st.wptr_r   = st_ff.wptr;
          nxt_st.wptr_p   = st_ff.wptr;
          nxt_st.empty_n  = (cnt_live != '0);
          nxt_st.full_n   = (cnt_live != PW'(DEPTH));
          nxt_st.afull_n  = !over_off(cnt_live, cfg.full_off);
          nxt_st.aempty_n = !under_off(cnt_live, cfg.empty_off);
        end else begin
          nxt_st.rec_cnt = st_ff.rec_cnt + 1'b1;
        end
      end
      default: nxt_st.mode = M_RST;
    endcase
    // device reset acts at once, whatever the clocks do
    if (!s_dev_rst_n) begin
      nxt_st        = ST_RST;
      nxt_st.wclk_q = s_wclk;
      nxt_st.rclk_q = s_rclk;
      nxt_st.wtok   = cfg.first_load;
      nxt_st.rtok   = cfg.first_load;
      nxt_st.q_oe_n = s_oe_n | (cfg.casc_en & ~cfg.first_load);
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage has no reset; contents are defined only once written
  always_ff @(posedge i_clk) begin
    if (wr_ok) begin
      mem[st_ff.wptr[AW-1:0]] <= s_d;
    end
  end

  assign o_q                = st_ff.q;
  assign o_q_oe_n           = st_ff.q_oe_n;
  assign o_empty_n          = st_ff.empty_n;
  assign o_full_n           = st_ff.full_n;
  assign o_almost_empty_n   = st_ff.aempty_n;
  assign o_almost_full_n    = st_ff.afull_n;
  assign o_half_full_n      = st_ff.half_n;
  assign o_wr_cascade_out_n = st_ff.wco_n;
  assign o_rd_cascade_out_n = st_ff.rco_n;
  assign cfg.flags = {st_ff.full_n, st_ff.afull_n, st_ff.half_n,
                      st_ff.aempty_n, st_ff.empty_n};
  assign cfg.count = CW'(cnt_live);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  wr_store_a:
    assert property (wr_ok && s_dev_rst_n
                     |=> st_ff.wptr == PW'($past(st_ff.wptr) + 1'b1))
    else $error("accepted write did not advance write pointer");
  rd_next_a:
    assert property (rd_ok && s_dev_rst_n
                     |=> st_ff.q == $past(mem[st_ff.rptr[AW-1:0]]))
    else $error("read did not present stored word");
  oe_float_a:
    assert property (s_oe_n |=> o_q_oe_n)
    else $error("outputs driven with output enable high");
  casc_drive_a:
    assert property (cfg.casc_en && !st_ff.rtok && s_dev_rst_n |=> o_q_oe_n)
    else $error("cascaded device drives without read token");
  full_block_a:
    assert property (!st_ff.full_n && s_dev_rst_n |=> $stable(st_ff.wptr))
    else $error("write pointer moved while full");
  empty_hold_a:
    assert property (!st_ff.empty_n && s_dev_rst_n |=> $stable(st_ff.q))
    else $error("output word changed while empty");
  dev_reset_a:
    assert property (!s_dev_rst_n |=> !o_empty_n && st_ff.wptr == '0
                     && st_ff.rptr == '0 && st_ff.mode == M_RST)
    else $error("device reset did not clear pointers");
  dev_resume_a:
    assert property (st_ff.mode == M_RST && s_dev_rst_n
                     |=> st_ff.mode == M_RUN)
    else $error("device did not resume after reset");
  empty_edge_a:
    assert property ($changed(st_ff.empty_n) |-> $past(redge)
                     || !$past(s_dev_rst_n) || $past(st_ff.mode) == M_REPLAY)
    else $error("empty flag changed off a read edge");
  full_edge_a:
    assert property ($changed(st_ff.full_n) |-> $past(wedge)
                     || !$past(s_dev_rst_n) || $past(st_ff.mode) == M_REPLAY)
    else $error("full flag changed off a write edge");
  replay_ptr_a:
    assert property (st_ff.mode == M_REPLAY && s_dev_rst_n
                     |=> st_ff.rptr == '0)
    else $error("replay left read pointer away from start");
  replay_done_a:
    assert property (st_ff.mode == M_REPLAY && !s_replay && s_dev_rst_n
                     |-> ##[1:6] st_ff.mode == M_RUN)
    else $error("replay recovery did not end in time");
  casc_pulse_a:
    assert property (wr_ok && cfg.casc_en && st_ff.wptr[AW-1:0] == '1
                     && s_dev_rst_n |=> !o_wr_cascade_out_n ##1
                     o_wr_cascade_out_n)
    else $error("write cascade pulse missing or too long");
endmodule : dual_clock_sync_fifo

// ==== pkg/fifo_defs.svh ====
// constants for the dual clock fifo block
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH
`define FIFO_AW_DEF           13
`define FIFO_DW_DEF           18
`define OFF_W                 14
`define OFF_RST               14'h007F
`define CLK_PERIOD_NS         25
`define FULL_SKEW_MIN_NS      5
`define EMPTY_SKEW_MIN_NS     5
`define PROG_FLAG_SKEW_MIN_NS 10
`define REPLAY_RECOVERY_NS    60
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULL_SKEW_CYC         `CEIL_CYC(`FULL_SKEW_MIN_NS)
`define EMPTY_SKEW_CYC        `CEIL_CYC(`EMPTY_SKEW_MIN_NS)
`define PROG_SKEW_CYC         `CEIL_CYC(`PROG_FLAG_SKEW_MIN_NS)
`define REPLAY_CYC            `CEIL_CYC(`REPLAY_RECOVERY_NS)
`define REG_CTRL              8'h00
`define REG_OFFS              8'h04
`define REG_STAT              8'h08
`define REG_NONE              8'hFF
`define HSIZE_WORD            3'h2
`define CTRL_CASC_BIT         0
`define CTRL_FIRST_BIT        1
`define OFFS_FULL_LSB         16
`endif

// ==== pkg/fifo_pkg.sv ====
// types shared by the fifo block
`include "fifo_defs.svh"
package fifo_pkg;
  typedef enum logic [1:0] {
    M_RST    = 2'h0,
    M_RUN    = 2'h1,
    M_REPLAY = 2'h3
  } mode_t;

  typedef struct packed {
    logic [7:0]        addr;
    logic              wr;
    logic              rdy;
    logic              err;
    logic [31:0]       rdata;
    logic              casc;
    logic              first;
    logic [`OFF_W-1:0] eoff;
    logic [`OFF_W-1:0] foff;
  } regs_st_t;
endpackage : fifo_pkg

// ==== pkg/fifo_cfg_if.sv ====
// configuration and status carrier between register file and core
`timescale 1ns/100ps
`include "fifo_defs.svh"
interface fifo_cfg_if;
  logic              casc_en;
  logic              first_load;
  logic [`OFF_W-1:0] empty_off;
  logic [`OFF_W-1:0] full_off;
  logic [4:0]        flags;
  logic [15:0]       count;
  modport regs (output casc_en, first_load, empty_off, full_off,
                input  flags, count);
  modport core (input  casc_en, first_load, empty_off, full_off,
                output flags, count);
endinterface : fifo_cfg_if

// ==== hdl/pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  logic         i_clk,
  input  logic         i_rst_n,
  input  logic [W-1:0] i_pin,
  output logic [W-1:0] o_lvl
);
  import fifo_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  // stage one feeds stage two only; a change counts once two and three agree
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.s1  = i_pin;
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    nxt_st.lvl = (st_ff.s2 & st_ff.s3) | (st_ff.lvl & (st_ff.s2 ^ st_ff.s3));
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= {4{RST_VAL}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_lvl = st_ff.lvl;
endmodule : pin_sync

// ==== hdl/fifo_regs.sv ====
// ahb-lite register file: control, flag offsets and status
`timescale 1ns/100ps
`include "fifo_defs.svh"
module fifo_regs (
  input  logic        i_clk,
  input  logic        i_rst_n,
  input  logic        i_hsel,
  input  logic [31:0] i_haddr,
  input  logic [1:0]  i_htrans,
  input  logic        i_hwrite,
  input  logic [2:0]  i_hsize,
  input  logic [31:0] i_hwdata,
  input  logic        i_hready,
  output logic        o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic        o_hresp,
  fifo_cfg_if.regs    cfg
);
  import fifo_pkg::*;

  localparam regs_st_t ST_RST = '{eoff: `OFF_RST, foff: `OFF_RST,
                                  rdy: 1'b1, addr: `REG_NONE, default: '0};

  regs_st_t st_ff;
  regs_st_t nxt_st;
  logic     take;
  logic     hit;

  assign take = i_hsel & i_htrans[1] & i_hready;
  // only aligned whole words in the low page decode; the rest reads zero
  assign hit  = (i_haddr[31:8] == 24'h000000) & (i_hsize == `HSIZE_WORD);

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.wr = 1'b0;
    // data phase of a write: hwdata stands now
    if (st_ff.wr) begin
      unique case (st_ff.addr)
        `REG_CTRL: begin
          nxt_st.casc  = i_hwdata[`CTRL_CASC_BIT];
          nxt_st.first = i_hwdata[`CTRL_FIRST_BIT];
        end
        `REG_OFFS: begin
          nxt_st.eoff = i_hwdata[`OFF_W-1:0];
          nxt_st.foff = i_hwdata[`OFFS_FULL_LSB +: `OFF_W];
        end
        default: ;
      endcase
    end
    // address phase; reads see a write still in its data phase
    if (take) begin
      nxt_st.addr = hit ? i_haddr[7:0] : `REG_NONE;
      nxt_st.wr   = i_hwrite;
      unique case (nxt_st.addr)
        `REG_CTRL: nxt_st.rdata = 32'({nxt_st.first, nxt_st.casc});
        `REG_OFFS: nxt_st.rdata = {2'h0, nxt_st.foff, 2'h0, nxt_st.eoff};
        `REG_STAT: nxt_st.rdata = {cfg.count, 11'h000, cfg.flags};
        default:   nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_hreadyout    = st_ff.rdy;
  assign o_hresp        = st_ff.err;
  assign o_hrdata       = st_ff.rdata;
  assign cfg.casc_en    = st_ff.casc;
  assign cfg.first_load = st_ff.first;
  assign cfg.empty_off  = st_ff.eoff;
  assign cfg.full_off   = st_ff.foff;
endmodule : fifo_regs

// ==== testbench/fifo_ctrl_model.sv ====
// writing and reading controller model on the fifo pins
`timescale 1ns/100ps
module fifo_ctrl_model (
  input  logic        i_clk,
  output logic        o_wclk,
  output logic        o_rclk,
  output logic        o_wen_n,
  output logic        o_ren_n,
  output logic [17:0] o_d
);
  logic [3:0] ph;

  initial begin
    ph = 4'h0;
    o_wen_n = 1'b1;
    o_ren_n = 1'b1;
    o_d = 18'h0;
  end

  // ten-cycle frame keeps each clock phase above the pin filter
  always @(posedge i_clk) ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
  assign o_wclk = (ph < 4'h5);
  assign o_rclk = (ph >= 4'h5);

  // enables and data move mid low phase, far from the filtered edge
  task automatic put_word(input logic [17:0] w);
    @(posedge i_clk iff ph == 4'h7);
    o_wen_n <= 1'b0;
    o_d <= w;
  endtask : put_word

  task automatic stop_wr();
    @(posedge i_clk iff ph == 4'h7);
    o_wen_n <= 1'b1;
    o_d <= ~o_d; // released bus must not keep showing the last word
  endtask : stop_wr

  task automatic get_word();
    @(posedge i_clk iff ph == 4'h2);
    o_ren_n <= 1'b0;
  endtask : get_word

  task automatic stop_rd();
    @(posedge i_clk iff ph == 4'h2);
    o_ren_n <= 1'b1;
  endtask : stop_rd
endmodule : fifo_ctrl_model

// ==== testbench/testbench.sv ====
// self-checking bench for the dual clock fifo
`timescale 1ns/100ps
`include "fifo_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import fifo_pkg::*;
  localparam int DEPTH = 16, N = 2, M = 3;
  logic        i_clk = 0, rst_n = 0, dev_rst_n = 1, oe_n = 0;
  logic        replay = 0, hwrite = 0, mon_on = 0, hready, hresp;
  logic        sel = 0, rci_n = 1, wco_n, rco_n;
  int          wco_cnt = 0, rco_cnt = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic        wclk, rclk, wen_n, ren_n, q_oe_n;
  logic        e_n, f_n, ae_n, af_n, hf_n;
  logic [17:0] d, q;
  logic [7:0]  seq = 0;
  logic [17:0] exp_q[$], hist[$];
  int          num_errors = 0, cmp_count = 0;

  always #12.5 i_clk = ~i_clk;

  fifo_ctrl_model ctl (.i_clk(i_clk), .o_wclk(wclk), .o_rclk(rclk),
    .o_wen_n(wen_n), .o_ren_n(ren_n), .o_d(d));

  dual_clock_sync_fifo #(.AW(4)) uut (.i_clk(i_clk), .i_rst_n(rst_n),
    .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(`HSIZE_WORD), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_wclk(wclk), .i_rclk(rclk), .i_wen_n(wen_n), .i_ren_n(ren_n),
    .i_oe_n(oe_n), .i_d(d), .i_replay_pulse(replay),
    .i_sync_flag_sel(sel), .i_dev_rst_n(dev_rst_n),
    .i_wr_cascade_in_n(1'b1), .i_rd_cascade_in_n(rci_n), .o_q(q),
    .o_q_oe_n(q_oe_n), .o_empty_n(e_n), .o_full_n(f_n),
    .o_almost_empty_n(ae_n), .o_almost_full_n(af_n),
    .o_half_full_n(hf_n), .o_wr_cascade_out_n(wco_n),
    .o_rd_cascade_out_n(rco_n));

  // one-cycle cascade pulses counted where they are settled
  always @(negedge i_clk) begin
    if (wco_n === 1'b0) wco_cnt++;
    if (rco_n === 1'b0) rco_cnt++;
  end

  // single ahb-lite transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    @(posedge i_clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr_word(input bit keep);
    logic [17:0] v;
    seq++;
    v = {10'($urandom()), seq};
    hist.push_back(v);
    if (keep) exp_q.push_back(v);
    ctl.put_word(v);
    ctl.stop_wr();
  endtask : wr_word

  task automatic rd_word();
    ctl.get_word();
    ctl.stop_rd();
  endtask : rd_word

  // flags and live count after both sides have seen the pointers
  task automatic chk(input int c);
    repeat (20) @(posedge i_clk);
    `CHK(e_n, c != 0)
    `CHK(f_n, c != DEPTH)
    `CHK(ae_n, c > N)
    `CHK(af_n, c < DEPTH - M)
    `CHK(hf_n, c <= DEPTH / 2)
    ahb(1'b0, 32'(`REG_STAT), 32'h0);
    `CHK(rd[31:16], 16'(c))
    `CHK(hresp, 1'b0)
  endtask : chk

  // every new word on the outputs must be the oldest noted one
  always @(q) if (mon_on) begin
    `CHK(q, exp_q.pop_front())
  end

  initial begin
    void'($urandom(32'hc51a));
    repeat (3) @(posedge i_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge i_clk); // idle while resets settle
    `CHK(q, 18'h0)
    `CHK(q_oe_n, 1'b0)
    oe_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    `CHK(q_oe_n, 1'b1)
    oe_n <= 1'b0;
    ahb(1'b1, 32'(`REG_OFFS), {2'h0, 14'(M), 2'h0, 14'(N)});
    ahb(1'b0, 32'(`REG_OFFS), 32'h0);
    `CHK(rd, {2'h0, 14'(M), 2'h0, 14'(N)})
    ahb(1'b0, 32'h10, 32'h0);
    `CHK(rd, 32'h0)
    mon_on = 1'b1;
    // replay after a partial read restarts at the first word
    repeat (4) wr_word(1'b1);
    repeat (2) rd_word();
    repeat (10) @(posedge i_clk);
    replay <= 1'b1;
    repeat (6) @(posedge i_clk);
    replay <= 1'b0;
    repeat (30) @(posedge i_clk); // recovery plus spare edges
    exp_q = hist;
    chk(4);
    repeat (4) rd_word();
    chk(0);
    // device reset with words stored and clocks running
    repeat (2) wr_word(1'b0);
    mon_on = 1'b0;
    dev_rst_n <= 1'b0; // no access while held low
    repeat (6) @(posedge i_clk);
    dev_rst_n <= 1'b1;
    chk(0);
    `CHK(q, 18'h0)
    mon_on = 1'b1;
    // fill past full, then drain past empty
    for (int i = 1; i <= DEPTH + 2; i++) begin
      wr_word(i <= DEPTH);
      chk(i > DEPTH ? DEPTH : i);
    end
    for (int i = 1; i <= DEPTH + 2; i++) begin
      rd_word();
      chk(i > DEPTH ? 0 : DEPTH - i);
    end
    // first device of a depth cascade, almost flags on the live count
    mon_on = 1'b0;
    sel <= 1'b1;
    ahb(1'b1, 32'(`REG_CTRL), 32'h3);
    ahb(1'b0, 32'(`REG_CTRL), 32'h0);
    `CHK(rd, 32'h3)
    dev_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    dev_rst_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    mon_on = 1'b1;
    repeat (DEPTH) wr_word(1'b1);
    chk(DEPTH);
    repeat (DEPTH) rd_word();
    chk(0);
    `CHK(q_oe_n, 1'b1)
    rci_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    rci_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    `CHK(q_oe_n, 1'b0)
    `CHK(wco_cnt, 1)
    `CHK(rco_cnt, 1)
    `CHK(exp_q.size(), 0)
    summarize();
  end

  initial begin
    repeat (30000) @(posedge i_clk);
    num_errors++;
    summarize();
  end

  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
endmodule : testbench
